// ---- rtl/g751_rx_irq_pkg.sv ----
package g751_rx_irq_pkg;

	// ==========================================
	// Register map
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam logic [11:0] ADDR_LIVE_1 = 12'h124;
	localparam logic [11:0] ADDR_LIVE_2 = 12'h126;
	localparam logic [11:0] ADDR_LATCHED_1 = 12'h128;
	localparam logic [11:0] ADDR_LATCHED_2 = 12'h12a;
	localparam logic [11:0] ADDR_IRQ_EN_1 = 12'h12c;
	localparam logic [11:0] ADDR_IRQ_EN_2 = 12'h12e;
	localparam logic [11:0] ADDR_FE_COUNT = 12'h134;

	// ==========================================
	// Field positions
	localparam int BIT_UNFRAMED_ONES = 8;
	localparam int BIT_A_BIT = 7;
	localparam int BIT_N_BIT = 6;
	localparam int BIT_ALIGN_CHANGE = 5;
	localparam int BIT_FRAME_LOST = 4;
	localparam int BIT_REMOTE_ALARM = 3;
	localparam int BIT_ALL_ONES = 2;
	localparam int BIT_MISALIGNED = 1;
	localparam int BIT_SIGNAL_ABSENT = 0;
	localparam int BIT_FRAMING_ERROR = 8;
	localparam int BIT_ERROR_NONZERO = 0;

	// ==========================================
	// Implemented bits and reset values
	localparam logic [15:0] ALARM_MASK = 16'h01ff;
	localparam logic [15:0] LIVE_1_MASK = 16'h01df;
	localparam logic [15:0] FE_MASK = 16'h0101;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_MAX = 16'hffff;

	// ==========================================
	// Live receive status from the framer
	typedef struct packed {
		logic unframed_ones;
		logic a_bit;
		logic n_bit;
		logic frame_lost;
		logic remote_alarm;
		logic all_ones_alarm;
		logic frame_misaligned;
		logic signal_absent;
	} rx_status_t;

	// Register read/write request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

endpackage

// ---- rtl/g751_rx_irq.sv ----
// Contract
// (RULE1) Unframed-ones flag, enable and port raise interrupt
// (RULE2) A-bit flag, enable and port raise interrupt
// (RULE3) N-bit flag, enable and port raise interrupt
// (RULE4) Alignment flag, enable and port raise interrupt
// (RULE5) Frame-lost flag, enable, port raise interrupt
// (RULE6) Remote-alarm flag, enable, port raise interrupt
// (RULE7) All-ones flag, enable and port raise interrupt
// (RULE8) Misaligned flag, enable and port raise interrupt
// (RULE9) Signal-absent flag, enable, port raise interrupt
// (RULE10) Framing-error flag, enable, port raise interrupt
// (RULE11) Count-nonzero flag, enable, port raise interrupt
// (RULE12) Hold sixteen-bit framing error count
// (RULE13) Count register loads only on monitor update
// (RULE14) Live status change sets its latched flag
// (RULE15) Nonzero status rising sets count flag
// (RULE16) Detected framing error sets its flag
// (RULE17) New differing alignment sets alignment flag
// (RULE18) Enabled sources ORed, gated by port enable
// (RULE19) Enables and count reset to zero
`timescale 1ns/1ps
`default_nettype none

module g751_rx_irq (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Register port
	input wire g751_rx_irq_pkg::reg_req_t req_in,
	output logic [15:0] rdata_out,
	output logic rvalid_out,
	// Framer events
	input wire g751_rx_irq_pkg::rx_status_t status_in,
	input wire logic align_change_in,
	input wire logic framing_error_in,
	input wire logic perf_monitor_update_in,
	// Global enable and interrupt
	input wire logic port_status_irq_en_in,
	output logic irq_out
);

	// ==========================================
	// Decode
	function automatic logic hit(input g751_rx_irq_pkg::reg_req_t r, input logic [11:0] a);
		hit = (r.addr == a);
	endfunction

	function automatic logic [15:0] live_vec(input g751_rx_irq_pkg::rx_status_t s);
		logic [15:0] v;
		v = g751_rx_irq_pkg::REG_RESET;
		v[g751_rx_irq_pkg::BIT_UNFRAMED_ONES] = s.unframed_ones;
		v[g751_rx_irq_pkg::BIT_A_BIT] = s.a_bit;
		v[g751_rx_irq_pkg::BIT_N_BIT] = s.n_bit;
		v[g751_rx_irq_pkg::BIT_FRAME_LOST] = s.frame_lost;
		v[g751_rx_irq_pkg::BIT_REMOTE_ALARM] = s.remote_alarm;
		v[g751_rx_irq_pkg::BIT_ALL_ONES] = s.all_ones_alarm;
		v[g751_rx_irq_pkg::BIT_MISALIGNED] = s.frame_misaligned;
		v[g751_rx_irq_pkg::BIT_SIGNAL_ABSENT] = s.signal_absent;
		live_vec = v;
	endfunction

	// ==========================================
	// State
	logic [15:0] alarm_irq_en_q, alarm_irq_en_d;
	logic [15:0] fe_irq_en_q, fe_irq_en_d;
	logic [15:0] alarm_latched_q, alarm_latched_d;
	logic [15:0] fe_latched_q, fe_latched_d;
	logic [15:0] prev_live_q, prev_live_d;
	logic primed_q, primed_d;
	logic [15:0] fe_accum_q, fe_accum_d;
	logic [15:0] fe_count_q, fe_count_d;
	logic nonzero_prev_q, nonzero_prev_d;
	logic irq_q, irq_d;
	logic [15:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [15:0] live_now;
	logic [15:0] alarm_set;
	logic [15:0] fe_set;
	logic error_nonzero_status;

	// ==========================================
	// Next state
	always_comb begin
		live_now = live_vec(status_in);
		error_nonzero_status = (fe_count_q != g751_rx_irq_pkg::REG_RESET);

		// (RULE14) Change in either direction
		alarm_set = primed_q ? (live_now ^ prev_live_q) : g751_rx_irq_pkg::REG_RESET;
		// (RULE17) New alignment event
		alarm_set[g751_rx_irq_pkg::BIT_ALIGN_CHANGE] = align_change_in;
		fe_set = g751_rx_irq_pkg::REG_RESET;
		// (RULE16) Framing error flag
		fe_set[g751_rx_irq_pkg::BIT_FRAMING_ERROR] = framing_error_in;
		// (RULE15) Nonzero rising edge
		fe_set[g751_rx_irq_pkg::BIT_ERROR_NONZERO] = error_nonzero_status & ~nonzero_prev_q;

		prev_live_d = live_now;
		primed_d = 1'b1;
		nonzero_prev_d = error_nonzero_status;
		alarm_irq_en_d = alarm_irq_en_q;
		fe_irq_en_d = fe_irq_en_q;
		alarm_latched_d = alarm_latched_q;
		fe_latched_d = fe_latched_q;

		if (req_in.wr && hit(req_in, g751_rx_irq_pkg::ADDR_IRQ_EN_1)) begin
			alarm_irq_en_d = req_in.wdata & g751_rx_irq_pkg::ALARM_MASK;
		end
		if (req_in.wr && hit(req_in, g751_rx_irq_pkg::ADDR_IRQ_EN_2)) begin
			fe_irq_en_d = req_in.wdata & g751_rx_irq_pkg::FE_MASK;
		end
		// Write one to clear; a set in the same cycle wins
		if (req_in.wr && hit(req_in, g751_rx_irq_pkg::ADDR_LATCHED_1)) begin
			alarm_latched_d = alarm_latched_q & ~req_in.wdata;
		end
		if (req_in.wr && hit(req_in, g751_rx_irq_pkg::ADDR_LATCHED_2)) begin
			fe_latched_d = fe_latched_q & ~req_in.wdata;
		end
		alarm_latched_d = (alarm_latched_d | alarm_set) & g751_rx_irq_pkg::ALARM_MASK;
		fe_latched_d = (fe_latched_d | fe_set) & g751_rx_irq_pkg::FE_MASK;

		// (RULE12) Saturating event accumulator
		fe_accum_d = fe_accum_q;
		fe_count_d = fe_count_q;
		if (perf_monitor_update_in) begin
			// (RULE13) Snapshot on monitor update
			fe_count_d = fe_accum_q;
			fe_accum_d = framing_error_in ? g751_rx_irq_pkg::COUNT_ONE : g751_rx_irq_pkg::REG_RESET;
		end else if (framing_error_in && fe_accum_q != g751_rx_irq_pkg::COUNT_MAX) begin
			fe_accum_d = fe_accum_q + g751_rx_irq_pkg::COUNT_ONE;
		end

		// (RULE1) (RULE2) (RULE3) (RULE4) (RULE5) Alarm sources
		// (RULE6) (RULE7) (RULE8) (RULE9) Alarm sources
		// (RULE10) (RULE11) Framing error sources
		// (RULE18) OR and port gate
		irq_d = port_status_irq_en_in &
			((|(alarm_latched_q & alarm_irq_en_q)) | (|(fe_latched_q & fe_irq_en_q)));

		rvalid_d = req_in.rd;
		rdata_d = rdata_q;
		if (req_in.rd) begin
			case (req_in.addr)
				g751_rx_irq_pkg::ADDR_LIVE_1: rdata_d = live_now & g751_rx_irq_pkg::LIVE_1_MASK;
				g751_rx_irq_pkg::ADDR_LIVE_2: begin
					rdata_d = g751_rx_irq_pkg::REG_RESET;
					rdata_d[g751_rx_irq_pkg::BIT_ERROR_NONZERO] = error_nonzero_status;
				end
				g751_rx_irq_pkg::ADDR_LATCHED_1: rdata_d = alarm_latched_q;
				g751_rx_irq_pkg::ADDR_LATCHED_2: rdata_d = fe_latched_q;
				g751_rx_irq_pkg::ADDR_IRQ_EN_1: rdata_d = alarm_irq_en_q;
				g751_rx_irq_pkg::ADDR_IRQ_EN_2: rdata_d = fe_irq_en_q;
				g751_rx_irq_pkg::ADDR_FE_COUNT: rdata_d = fe_count_q;
				default: rdata_d = g751_rx_irq_pkg::REG_RESET;
			endcase
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			// (RULE19) Everything disabled
			alarm_irq_en_q <= g751_rx_irq_pkg::REG_RESET;
			fe_irq_en_q <= g751_rx_irq_pkg::REG_RESET;
			alarm_latched_q <= g751_rx_irq_pkg::REG_RESET;
			fe_latched_q <= g751_rx_irq_pkg::REG_RESET;
			prev_live_q <= g751_rx_irq_pkg::REG_RESET;
			primed_q <= 1'b0;
			fe_accum_q <= g751_rx_irq_pkg::REG_RESET;
			fe_count_q <= g751_rx_irq_pkg::REG_RESET;
			nonzero_prev_q <= 1'b0;
			irq_q <= 1'b0;
			rdata_q <= g751_rx_irq_pkg::REG_RESET;
			rvalid_q <= 1'b0;
		end else begin
			alarm_irq_en_q <= alarm_irq_en_d;
			fe_irq_en_q <= fe_irq_en_d;
			alarm_latched_q <= alarm_latched_d;
			fe_latched_q <= fe_latched_d;
			prev_live_q <= prev_live_d;
			primed_q <= primed_d;
			fe_accum_q <= fe_accum_d;
			fe_count_q <= fe_count_d;
			nonzero_prev_q <= nonzero_prev_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign irq_out = irq_q;
	assign rdata_out = rdata_q;
	assign rvalid_out = rvalid_q;

	// ==========================================
	// Assertions
	AST_UNFRAMED_ONES: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE1)
		alarm_latched_q[8] && alarm_irq_en_q[8] && port_status_irq_en_in |=> irq_out)
		else $error("unframed ones interrupt missing");
	AST_A_BIT: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE2)
		alarm_latched_q[7] && alarm_irq_en_q[7] && port_status_irq_en_in |=> irq_out)
		else $error("a bit interrupt missing");
	AST_N_BIT: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE3)
		alarm_latched_q[6] && alarm_irq_en_q[6] && port_status_irq_en_in |=> irq_out)
		else $error("n bit interrupt missing");
	AST_ALIGN: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE4)
		alarm_latched_q[5] && alarm_irq_en_q[5] && port_status_irq_en_in |=> irq_out)
		else $error("alignment interrupt missing");
	AST_FRAME_LOST: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE5)
		alarm_latched_q[4] && alarm_irq_en_q[4] && port_status_irq_en_in |=> irq_out)
		else $error("frame lost interrupt missing");
	AST_REMOTE: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE6)
		alarm_latched_q[3] && alarm_irq_en_q[3] && port_status_irq_en_in |=> irq_out)
		else $error("remote alarm interrupt missing");
	AST_ALL_ONES: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE7)
		alarm_latched_q[2] && alarm_irq_en_q[2] && port_status_irq_en_in |=> irq_out)
		else $error("all ones interrupt missing");
	AST_MISALIGN: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE8)
		alarm_latched_q[1] && alarm_irq_en_q[1] && port_status_irq_en_in |=> irq_out)
		else $error("misaligned interrupt missing");
	AST_SIG_ABSENT: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE9)
		alarm_latched_q[0] && alarm_irq_en_q[0] && port_status_irq_en_in |=> irq_out)
		else $error("signal absent interrupt missing");
	AST_FE_FLAG: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE10)
		fe_latched_q[8] && fe_irq_en_q[8] && port_status_irq_en_in |=> irq_out)
		else $error("framing error interrupt missing");
	AST_NONZERO: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE11)
		fe_latched_q[0] && fe_irq_en_q[0] && port_status_irq_en_in |=> irq_out)
		else $error("count nonzero interrupt missing");
	AST_COUNT_HOLD: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE13)
		!perf_monitor_update_in |=> $stable(fe_count_q))
		else $error("count changed without update");
	AST_COUNT_LOAD: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE12)
		perf_monitor_update_in |=> fe_count_q == $past(fe_accum_q))
		else $error("count not loaded from accumulator");
	AST_CHANGE_SET: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE14)
		primed_q && (status_in.frame_lost != prev_live_q[4]) |=> alarm_latched_q[4])
		else $error("frame lost change not latched");
	AST_NONZERO_SET: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE15)
		$rose(error_nonzero_status) |=> fe_latched_q[0])
		else $error("nonzero rise not latched");
	AST_FE_SET: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE16)
		framing_error_in |=> fe_latched_q[8])
		else $error("framing error not latched");
	AST_ALIGN_SET: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE17)
		align_change_in |=> alarm_latched_q[5])
		else $error("alignment change not latched");
	AST_GATE: assert property (@(posedge clk_in) disable iff (!resetn_in) // (RULE18)
		!port_status_irq_en_in |=> !irq_out)
		else $error("interrupt without port enable");
	AST_RESET: assert property (@(posedge clk_in) // (RULE19)
		!resetn_in |=> alarm_irq_en_q == 16'h0000 && fe_irq_en_q == 16'h0000 && fe_count_q == 16'h0000)
		else $error("enables or count not cleared by reset");

	COV_IRQ: cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(irq_out));
	COV_CLEAR: cover property (@(posedge clk_in) disable iff (!resetn_in) $fell(irq_out));
	COV_LOAD: cover property (@(posedge clk_in) disable iff (!resetn_in)
		perf_monitor_update_in && framing_error_in);
	COV_SET_CLEAR: cover property (@(posedge clk_in) disable iff (!resetn_in)
		framing_error_in && req_in.wr && req_in.addr == g751_rx_irq_pkg::ADDR_LATCHED_2);

endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk_in;
	logic resetn_in;
	g751_rx_irq_pkg::reg_req_t req;
	logic [15:0] rdata_out;
	logic rvalid_out;
	logic [7:0] st_bits;
	logic align_change;
	logic framing_error;
	logic perf_monitor_update;
	logic port_en;
	logic irq_out;
	int fails;
	int n_checks;
	// Latched bit position of each event source within its latched register
	int lat_bit [11] = '{0, 1, 2, 3, 4, 6, 7, 8, 5, 8, 0};

	g751_rx_irq u_dut (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.req_in(req),
		.rdata_out(rdata_out),
		.rvalid_out(rvalid_out),
		.status_in(g751_rx_irq_pkg::rx_status_t'(st_bits)),
		.align_change_in(align_change),
		.framing_error_in(framing_error),
		.perf_monitor_update_in(perf_monitor_update),
		.port_status_irq_en_in(port_en),
		.irq_out(irq_out)
	);

	// ==========================================
	// Clock, watchdog and verdict
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	initial begin
		#100000;
		fails = fails + 1;
		print_verdict();
	end

	task automatic print_verdict();
		if (fails == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================
	// Access tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] addr, input logic [15:0] data);
		req.wr = 1'b1;
		req.addr = addr;
		req.wdata = data;
		tick(1);
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [11:0] addr, input logic [15:0] exp);
		req.rd = 1'b1;
		req.addr = addr;
		tick(1);
		req.rd = 1'b0;
		chk({15'h0000, rvalid_out}, 16'h0001);
		chk(rdata_out, exp);
	endtask

	task automatic ev(input int k);
		if (k < 8) begin
			st_bits[k] = ~st_bits[k];
			tick(1);
		end else begin
			align_change = (k == 8);
			framing_error = (k == 9);
			perf_monitor_update = (k == 10);
			tick(1);
			align_change = 1'b0;
			framing_error = 1'b0;
			perf_monitor_update = 1'b0;
		end
	endtask

	// One source: raise, gate by port enable, clear
	task automatic src_test(input int k);
		logic [11:0] la;
		logic [11:0] ea;
		logic [15:0] m;
		la = (k > 8) ? g751_rx_irq_pkg::ADDR_LATCHED_2 : g751_rx_irq_pkg::ADDR_LATCHED_1;
		ea = (k > 8) ? g751_rx_irq_pkg::ADDR_IRQ_EN_2 : g751_rx_irq_pkg::ADDR_IRQ_EN_1;
		m = 16'h0001 << lat_bit[k];
		wr(ea, m);
		ev(k);
		tick(3);
		chk({15'h0000, irq_out}, 16'h0001);
		rd(la, m);
		port_en = 1'b0;
		tick(2);
		chk({15'h0000, irq_out}, 16'h0000);
		port_en = 1'b1;
		wr(la, m);
		tick(2);
		chk({15'h0000, irq_out}, 16'h0000);
		rd(la, 16'h0000);
		wr(ea, 16'h0000);
	endtask

	// ==========================================
	// Test sequence
	initial begin
		fails = 0;
		n_checks = 0;
		resetn_in = 1'b0;
		req = '0;
		st_bits = 8'h00;
		align_change = 1'b0;
		framing_error = 1'b0;
		perf_monitor_update = 1'b0;
		port_en = 1'b1;
		tick(20);
		chk({15'h0000, irq_out}, 16'h0000);
		resetn_in = 1'b1;
		tick(2);
		// Reset values
		rd(g751_rx_irq_pkg::ADDR_IRQ_EN_1, 16'h0000);
		rd(g751_rx_irq_pkg::ADDR_IRQ_EN_2, 16'h0000);
		rd(g751_rx_irq_pkg::ADDR_FE_COUNT, 16'h0000);
		rd(12'h130, 16'h0000);
		// Implemented enable bits only
		wr(g751_rx_irq_pkg::ADDR_IRQ_EN_1, 16'hffff);
		rd(g751_rx_irq_pkg::ADDR_IRQ_EN_1, 16'h01ff);
		wr(g751_rx_irq_pkg::ADDR_IRQ_EN_2, 16'hffff);
		rd(g751_rx_irq_pkg::ADDR_IRQ_EN_2, 16'h0101);
		wr(g751_rx_irq_pkg::ADDR_IRQ_EN_1, 16'h0000);
		wr(g751_rx_irq_pkg::ADDR_IRQ_EN_2, 16'h0000);
		// Status sources twice for both edges, then align, error, count
		for (int k = 0; k < 11; k++) begin
			if (k == 10) begin
				rd(g751_rx_irq_pkg::ADDR_FE_COUNT, 16'h0000);
			end
			repeat ((k < 8) ? 2 : 1) src_test(k);
		end
		rd(g751_rx_irq_pkg::ADDR_FE_COUNT, 16'h0001);
		rd(g751_rx_irq_pkg::ADDR_LIVE_2, 16'h0001);
		// Back-to-back errors held until snapshot
		framing_error = 1'b1;
		tick(3);
		framing_error = 1'b0;
		tick(2);
		rd(g751_rx_irq_pkg::ADDR_FE_COUNT, 16'h0001);
		wr(g751_rx_irq_pkg::ADDR_LATCHED_2, 16'h0100);
		ev(10);
		tick(2);
		rd(g751_rx_irq_pkg::ADDR_FE_COUNT, 16'h0003);
		rd(g751_rx_irq_pkg::ADDR_LATCHED_2, 16'h0000);
		wr(g751_rx_irq_pkg::ADDR_FE_COUNT, 16'hffff);
		rd(g751_rx_irq_pkg::ADDR_FE_COUNT, 16'h0003);
		// Live status readback and all eight status sources changing at once
		st_bits = 8'hff;
		tick(1);
		rd(g751_rx_irq_pkg::ADDR_LIVE_1, 16'h01df);
		rd(g751_rx_irq_pkg::ADDR_LATCHED_1, 16'h01df);
		wr(g751_rx_irq_pkg::ADDR_LATCHED_1, 16'h01ff);
		// Second reset clears enables and count
		wr(g751_rx_irq_pkg::ADDR_IRQ_EN_1, 16'h01ff);
		resetn_in = 1'b0;
		tick(2);
		resetn_in = 1'b1;
		tick(2);
		rd(g751_rx_irq_pkg::ADDR_IRQ_EN_1, 16'h0000);
		rd(g751_rx_irq_pkg::ADDR_FE_COUNT, 16'h0000);
		rd(g751_rx_irq_pkg::ADDR_LATCHED_1, 16'h0000);
		print_verdict();
	end
endmodule

`default_nettype wire
